// ===== rtl/reload_down_timer_defines.svh
`ifndef RELOAD_DOWN_TIMER_DEFINES_SVH
`define RELOAD_DOWN_TIMER_DEFINES_SVH

// apb byte offsets, channel n sits at n * stride
`define RT_CH_STRIDE    8'h10
`define RT_OFF_CTRL     4'h0
`define RT_OFF_RELOAD   4'h4
`define RT_OFF_COUNT    4'h8
`define RT_OFF_STATUS   8'h20
`define RT_OFF_MASK     8'h24

// control word fields
`define RT_CSEL_LSB     0
`define RT_RELOAD_BIT   2
`define RT_ENABLE_BIT   3
`define RT_TRIG_LSB     4
`define RT_EVT_LSB      6
`define RT_ATS_BIT      8
`define RT_SWTRIG_BIT   9
`define RT_RUN_BIT      10
`define RT_CTRL_W       9
`define RT_CTRL_RESET   9'h000
`define RT_RELOAD_RESET 16'h0000
`define RT_COUNT_RESET  16'h0000
`define RT_COUNT_WRAP   16'hffff

// count clock select value that means event count mode
`define RT_SEL_EVENT    2'h3

// prescaler: internal count clocks at clk/2, clk/8 and clk/32
`define RT_DIV_W        5
`define RT_DIV0_MASK    5'h01
`define RT_DIV1_MASK    5'h07
`define RT_DIV2_MASK    5'h1f

// edge select encodings for trigger and event inputs
`define RT_EDGE_NONE    2'h0
`define RT_EDGE_RISE    2'h1
`define RT_EDGE_FALL    2'h2
`define RT_EDGE_BOTH    2'h3

`endif

// ===== rtl/reload_timer_pkg.sv
package reload_timer_pkg;

    typedef logic [15:0] count_t;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } chan_state_e;

endpackage

// ===== rtl/reload_timer_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "reload_down_timer_defines.svh"

module reload_timer_channel
    import reload_timer_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] clk_sel,
    input  wire logic       reload_mode,
    input  wire logic       enable,
    input  wire logic       launch,
    input  wire logic [2:0] int_tick,
    input  wire logic       event_hit,
    input  wire count_t     reload_val,
    output logic     [15:0] count,
    output logic            running,
    output logic            underflow
);

    chan_state_e state_ff;
    chan_state_e nxt_state;
    count_t      count_ff;
    count_t      nxt_count;
    logic        uf_ff;
    logic        nxt_uf;
    logic        tick;

    // pick the count clock for this channel [RQ1] [RQ10]
    always_comb begin
        case (clk_sel)
            2'h0:    tick = int_tick[0];
            2'h1:    tick = int_tick[1];
            2'h2:    tick = int_tick[2];
            default: tick = event_hit;
        endcase
    end

    // launch wins over a count tick in the same cycle
    always_comb begin
        nxt_state = state_ff;
        nxt_count = count_ff;
        nxt_uf    = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (enable && launch) begin
                    nxt_count = reload_val; // [RQ11]
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!enable) begin
                    nxt_state = ST_IDLE;
                end else if (launch) begin
                    nxt_count = reload_val; // [RQ11]
                end else if (tick) begin
                    if (count_ff == 16'h0000) begin
                        nxt_uf = 1'b1; // [RQ3]
                        if (reload_mode) begin
                            nxt_count = reload_val; // [RQ5]
                        end else begin
                            nxt_count = `RT_COUNT_WRAP; // [RQ4]
                            nxt_state = ST_IDLE; // [RQ4]
                        end
                    end else begin
                        nxt_count = count_ff - 16'h0001; // [RQ7]
                    end
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            count_ff <= `RT_COUNT_RESET;
            uf_ff    <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            count_ff <= nxt_count;
            uf_ff    <= nxt_uf;
        end
    end

    assign count     = count_ff;
    assign running   = (state_ff == ST_RUN);
    assign underflow = uf_ff;

endmodule // reload_timer_channel

`default_nettype wire

// ===== rtl/reload_down_timer.sv
// What this block does
// (RQ1) count clock is one of three divided internal clocks or external events
// (RQ2) launch by software or by a detected edge on the trigger pin
// (RQ3) underflow of the 16-bit counter raises an interrupt request
// (RQ4) one-shot mode halts the counter on underflow until relaunched
// (RQ5) reload mode copies the reload value on underflow and keeps counting
// (RQ6) select values 00, 01, 10 pick three different internal clock intervals
// (RQ7) internal mode decrements by one on each selected internal tick
// (RQ8) underflow may start the auto transfer service instead of an interrupt
// (RQ9) two independent channels, each with counter, reload, control, request
// (RQ10) select value 11 counts event edges; only software may launch
// (RQ11) launch loads the reload value and counts from the next tick
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "reload_down_timer_defines.svh"

module reload_down_timer
    import reload_timer_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  trig_pin,
    input  wire logic [1:0]  event_pin,
    output logic             irq,
    output logic      [1:0]  auto_transfer_service
);

    logic [31:0]          prdata_ff;
    logic                 pready_ff;
    logic                 pslverr_ff;
    logic                 irq_ff;
    logic [1:0]           xfer_ff;
    logic [`RT_CTRL_W-1:0] ctrl_ff [2];
    count_t               reload_ff [2];
    logic [1:0]           swtrig_ff;
    logic [1:0]           status_ff;
    logic [1:0]           mask_ff;
    logic [1:0]           trig_s1_ff;
    logic [1:0]           trig_s2_ff;
    logic [1:0]           trig_s3_ff;
    logic [1:0]           evt_s1_ff;
    logic [1:0]           evt_s2_ff;
    logic [1:0]           evt_s3_ff;
    logic [`RT_DIV_W-1:0] pre_ff;
    logic [2:0]           tick_ff;
    logic [1:0]           nxt_status;
    logic [31:0]          nxt_prdata;
    logic                 access;
    logic                 done;
    logic                 wr;
    logic                 hit;
    logic [1:0]           launch;
    logic [1:0]           event_hit;
    logic [1:0]           trig_hit;
    logic [1:0]           running;
    logic [1:0]           underflow;
    logic [15:0]          count_w [2];

    // edge detector used for trigger and event inputs of both channels
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic prev,
                                      input logic cur);
        case (sel)
            `RT_EDGE_RISE: edge_hit = cur & ~prev;
            `RT_EDGE_FALL: edge_hit = prev & ~cur;
            `RT_EDGE_BOTH: edge_hit = cur ^ prev;
            default:       edge_hit = 1'b0;
        endcase
    endfunction

    // address decode for the slave error, which also blocks writes to unmapped words
    function automatic logic addr_ok(input logic [7:0] a);
        if (a[7:5] == 3'h0) begin
            addr_ok = (a[3:0] == `RT_OFF_CTRL) || (a[3:0] == `RT_OFF_RELOAD)
                   || (a[3:0] == `RT_OFF_COUNT);
        end else begin
            addr_ok = (a == `RT_OFF_STATUS) || (a == `RT_OFF_MASK);
        end
    endfunction

    // apb: one wait state, so the answer is a flop and never a comb path
    assign access = psel && penable && !pready_ff;
    assign done   = psel && penable && pready_ff;
    assign hit    = addr_ok(paddr);
    assign wr     = done && pwrite && !pslverr_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= access;
            pslverr_ff <= access && !hit;
        end
    end

    // read mux, captured in the first access cycle
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (paddr[7:5] == 3'h0) begin
            case (paddr[3:0])
                `RT_OFF_CTRL: begin
                    nxt_prdata[`RT_CTRL_W-1:0] = ctrl_ff[paddr[4]];
                    nxt_prdata[`RT_RUN_BIT]    = running[paddr[4]];
                end
                `RT_OFF_RELOAD: nxt_prdata[15:0] = reload_ff[paddr[4]];
                `RT_OFF_COUNT:  nxt_prdata[15:0] = count_w[paddr[4]];
                default:        nxt_prdata = 32'h0000_0000;
            endcase
        end else if (paddr == `RT_OFF_STATUS) begin
            nxt_prdata[1:0] = status_ff;
        end else if (paddr == `RT_OFF_MASK) begin
            nxt_prdata[1:0] = mask_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_ff <= 32'h0000_0000;
        end else if (access) begin
            prdata_ff <= nxt_prdata;
        end else if (done) begin
            prdata_ff <= 32'h0000_0000;
        end
    end

    // per channel control and reload registers [RQ9]
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff[0]   <= `RT_CTRL_RESET;
            ctrl_ff[1]   <= `RT_CTRL_RESET;
            reload_ff[0] <= `RT_RELOAD_RESET;
            reload_ff[1] <= `RT_RELOAD_RESET;
        end else if (wr && paddr[7:5] == 3'h0) begin
            if (paddr[3:0] == `RT_OFF_CTRL) begin
                ctrl_ff[paddr[4]] <= pwdata[`RT_CTRL_W-1:0];
            end
            if (paddr[3:0] == `RT_OFF_RELOAD) begin
                reload_ff[paddr[4]] <= pwdata[15:0];
            end
        end
    end

    // software trigger is a write-one pulse, it reads back as zero [RQ2]
    always_ff @(posedge clk) begin
        if (rst) begin
            swtrig_ff <= 2'h0;
        end else begin
            swtrig_ff <= 2'h0;
            if (wr && paddr[7:5] == 3'h0 && paddr[3:0] == `RT_OFF_CTRL) begin
                swtrig_ff[paddr[4]] <= pwdata[`RT_SWTRIG_BIT];
            end
        end
    end

    // pins are asynchronous: two flops, then a third for edge history
    always_ff @(posedge clk) begin
        if (rst) begin
            trig_s1_ff <= 2'h0;
            trig_s2_ff <= 2'h0;
            trig_s3_ff <= 2'h0;
            evt_s1_ff  <= 2'h0;
            evt_s2_ff  <= 2'h0;
            evt_s3_ff  <= 2'h0;
        end else begin
            trig_s1_ff <= trig_pin;
            trig_s2_ff <= trig_s1_ff;
            trig_s3_ff <= trig_s2_ff;
            evt_s1_ff  <= event_pin;
            evt_s2_ff  <= evt_s1_ff;
            evt_s3_ff  <= evt_s2_ff;
        end
    end

    // free running prescaler giving three internal count clocks [RQ1] [RQ6]
    always_ff @(posedge clk) begin
        if (rst) begin
            pre_ff  <= {`RT_DIV_W{1'b0}};
            tick_ff <= 3'h0;
        end else begin
            pre_ff     <= pre_ff + 5'h01;
            tick_ff[0] <= (pre_ff & `RT_DIV0_MASK) == `RT_DIV0_MASK;
            tick_ff[1] <= (pre_ff & `RT_DIV1_MASK) == `RT_DIV1_MASK;
            tick_ff[2] <= (pre_ff & `RT_DIV2_MASK) == `RT_DIV2_MASK;
        end
    end

    // sticky status, set wins over a write-one clear in the same cycle [RQ3]
    always_comb begin
        nxt_status = status_ff;
        if (wr && paddr == `RT_OFF_STATUS) begin
            nxt_status = status_ff & ~pwdata[1:0];
        end
        for (int i = 0; i < 2; i++) begin
            if (underflow[i] && !ctrl_ff[i][`RT_ATS_BIT]) begin
                nxt_status[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_ff <= 2'h0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask_ff <= 2'h0;
        end else if (wr && paddr == `RT_OFF_MASK) begin
            mask_ff <= pwdata[1:0];
        end
    end

    // level interrupt from unmasked status [RQ3]
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_status & mask_ff);
        end
    end

    // underflow goes to the transfer service when selected [RQ8]
    always_ff @(posedge clk) begin
        if (rst) begin
            xfer_ff <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                xfer_ff[i] <= underflow[i] && ctrl_ff[i][`RT_ATS_BIT];
            end
        end
    end

    // two identical channels [RQ9]
    for (genvar g = 0; g < 2; g++) begin : g_ch
        logic [1:0] csel;
        assign csel = ctrl_ff[g][`RT_CSEL_LSB +: 2];

        // external trigger only in internal clock mode [RQ2] [RQ10]
        assign trig_hit[g]  = edge_hit(ctrl_ff[g][`RT_TRIG_LSB +: 2],
                                       trig_s3_ff[g], trig_s2_ff[g]);
        assign launch[g]    = swtrig_ff[g] || (trig_hit[g] && csel != `RT_SEL_EVENT);
        assign event_hit[g] = edge_hit(ctrl_ff[g][`RT_EVT_LSB +: 2],
                                       evt_s3_ff[g], evt_s2_ff[g]);

        reload_timer_channel u_chan (
            .clk         (clk),
            .rst         (rst),
            .clk_sel     (csel),
            .reload_mode (ctrl_ff[g][`RT_RELOAD_BIT]),
            .enable      (ctrl_ff[g][`RT_ENABLE_BIT]),
            .launch      (launch[g]),
            .int_tick    (tick_ff),
            .event_hit   (event_hit[g]),
            .reload_val  (reload_ff[g]),
            .count       (count_w[g]),
            .running     (running[g]),
            .underflow   (underflow[g])
        );

        property p_uf_status;
            @(posedge clk) disable iff (rst)
            underflow[g] && !ctrl_ff[g][`RT_ATS_BIT] |=> status_ff[g];
        endproperty
        a_uf_status: assert property (p_uf_status) // [RQ3]
            else $error("underflow did not set status");

        property p_ats;
            @(posedge clk) disable iff (rst)
            underflow[g] && ctrl_ff[g][`RT_ATS_BIT]
                |=> auto_transfer_service[g] && !$changed(status_ff[g]) ##1
                    !auto_transfer_service[g];
        endproperty
        a_ats: assert property (p_ats) // [RQ8]
            else $error("transfer request wrong on underflow");

        property p_oneshot;
            @(posedge clk) disable iff (rst)
            underflow[g] && !ctrl_ff[g][`RT_RELOAD_BIT] && !launch[g]
                |-> !running[g] && count_w[g] == 16'hffff ##1 !running[g];
        endproperty
        a_oneshot: assert property (p_oneshot) // [RQ4]
            else $error("one-shot did not halt");

        property p_reload;
            @(posedge clk) disable iff (rst)
            underflow[g] && ctrl_ff[g][`RT_RELOAD_BIT]
                |-> running[g] && count_w[g] == $past(reload_ff[g]);
        endproperty
        a_reload: assert property (p_reload) // [RQ5]
            else $error("reload mode did not reload");

        property p_launch;
            @(posedge clk) disable iff (rst)
            launch[g] && ctrl_ff[g][`RT_ENABLE_BIT]
                |=> running[g] && count_w[g] == $past(reload_ff[g]);
        endproperty
        a_launch: assert property (p_launch) // [RQ11] [RQ2]
            else $error("launch did not load reload value");

        property p_dec;
            @(posedge clk) disable iff (rst)
            running[g] && csel != `RT_SEL_EVENT && tick_ff[csel]
                && ctrl_ff[g][`RT_ENABLE_BIT] && !launch[g] && count_w[g] != 16'h0000
                |=> count_w[g] == $past(count_w[g]) - 16'h0001;
        endproperty
        a_dec: assert property (p_dec) // [RQ7]
            else $error("internal tick did not decrement");

        property p_evt;
            @(posedge clk) disable iff (rst)
            csel == `RT_SEL_EVENT && !running[g] && !swtrig_ff[g]
                |=> !running[g];
        endproperty
        a_evt: assert property (p_evt) // [RQ10]
            else $error("event mode launched without software");
    end

    property p_div1;
        @(posedge clk) disable iff (rst)
        tick_ff[1] |=> !tick_ff[1] [*7] ##1 tick_ff[1];
    endproperty
    a_div1: assert property (p_div1) // [RQ6] [RQ1]
        else $error("second internal clock period wrong");

    property p_div0;
        @(posedge clk) disable iff (rst)
        tick_ff[0] |=> !tick_ff[0] ##1 tick_ff[0];
    endproperty
    a_div0: assert property (p_div0) // [RQ6]
        else $error("first internal clock period wrong");

    property p_irq;
        @(posedge clk) disable iff (rst)
        $rose(status_ff[0]) && $past(mask_ff[0]) |-> irq; // irq is built from the old mask
    endproperty
    a_irq: assert property (p_irq) // [RQ3]
        else $error("interrupt not raised with status");

    property p_apb;
        @(posedge clk) disable iff (rst)
        psel && penable && !pready |=> pready;
    endproperty
    a_apb: assert property (p_apb)
        else $error("apb answer late");

    assign prdata                = prdata_ff;
    assign pready                = pready_ff;
    assign pslverr               = pslverr_ff;
    assign irq                   = irq_ff;
    assign auto_transfer_service = xfer_ff;

endmodule // reload_down_timer

`default_nettype wire

// ===== bench/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
    input  wire logic       clk,
    output logic      [1:0] trig_pin,
    output logic      [1:0] event_pin
);
    // pins rest low between pulses, so every pulse is one clean edge pair
    initial begin
        trig_pin  = 2'h0;
        event_pin = 2'h0;
    end

    // high for four cycles: long enough to survive the two-flop synchroniser
    task automatic pulse_trig(input int ch);
        @(posedge clk);
        trig_pin[ch] <= 1'b1;
        repeat (4) @(posedge clk);
        trig_pin[ch] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // one event clock period, rising then falling
    task automatic pulse_event(input int ch);
        @(posedge clk);
        event_pin[ch] <= 1'b1;
        repeat (4) @(posedge clk);
        event_pin[ch] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule // pin_partner

`default_nettype wire

// ===== bench/reload_down_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "reload_down_timer_defines.svh"

module reload_down_timer_test;
    localparam logic [31:0] RLD = 32'h0000_0004;
    localparam logic [31:0] EN  = 32'h0000_0008;
    localparam logic [31:0] ATS = 32'h0000_0100;
    localparam logic [31:0] SWT = 32'h0000_0200;
    localparam logic [31:0] RUN = 32'h0000_0400;
    localparam logic [7:0]  STA = `RT_OFF_STATUS;
    localparam logic [7:0]  MSK = `RT_OFF_MASK;

    logic        clk;
    logic        rst;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  trig_pin;
    logic [1:0]  event_pin;
    logic        irq;
    logic [1:0]  ats_pulse;
    logic [31:0] rdat;
    logic        perr;
    int          failures;
    int          check_count;

    reload_down_timer u_reload_down_timer (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trig_pin(trig_pin), .event_pin(event_pin), .irq(irq),
        .auto_transfer_service(ats_pulse)
    );

    pin_partner u_pin_partner (
        .clk(clk), .trig_pin(trig_pin), .event_pin(event_pin)
    );

    // 250 mhz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic give_up();
        failures++;
        $display("unexpected at %0t: wait ran out", $time);
        conclude();
    endtask

    // one apb transfer; the request holds until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) give_up();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
        xfer(1'b0, a, 32'h0);
        check(rdat, e, m);
    endtask

    // sel 0 waits for the channel 0 transfer pulse, sel 1 for irq
    task automatic wait_hi(input int sel, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (((sel == 1) ? irq : ats_pulse[0]) !== 1'b1 && n < 3000);
        if (n >= 3000) give_up();
    endtask

    // every mapped word reads zero after reset; holes answer with an error
    task automatic t_reset();
        logic [7:0] a;
        logic       hole;
        for (int i = 0; i < 12; i++) begin
            a = 8'(i * 4);
            hole = !(a inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, STA, MSK});
            xfer(1'b0, a, 32'h0);
            check(rdat, 32'h0, "reset value");
            check({31'h0, perr}, {31'h0, hole}, "slave error");
        end
        $display("test reset done");
    endtask

    // reload 3 gives four ticks per period; skip two pulses to drop stale ones
    task automatic t_reload();
        int n;
        wr(8'h04, 32'h3);
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, 32'(i) | RLD | EN | ATS | SWT);
            wait_hi(0, n);
            wait_hi(0, n);
            wait_hi(0, n);
            check(32'(n), 32'(8 << (2 * i)), "reload period");
        end
        wr(8'h00, 32'h0);
        rd(STA, 32'h0, "status under transfer service");
        $display("test reload done");
    endtask

    task automatic t_oneshot();
        int n;
        wr(8'h04, 32'h1);
        wr(MSK, 32'h1);
        wr(8'h00, EN | SWT);
        wait_hi(1, n);
        rd(STA, 32'h1, "underflow status");
        rd(8'h08, 32'hffff, "halted count");
        rd(8'h00, EN, "stopped");
        repeat (40) @(posedge clk);
        rd(8'h08, 32'hffff, "still halted");
        wr(8'h00, SWT);
        rd(8'h00, 32'h0, "launch while disabled");
        wr(MSK, 32'h0);
        repeat (3) @(posedge clk);
        #1 check({31'h0, irq}, 32'h0, "masked irq");
        wr(MSK, 32'h1);
        repeat (3) @(posedge clk);
        #1 check({31'h0, irq}, 32'h1, "unmasked irq");
        wr(STA, 32'h1);
        rd(STA, 32'h0, "cleared status");
        #1 check({31'h0, irq}, 32'h0, "irq after clear");
        $display("test one-shot done");
    endtask

    // channel 1, clk/32, falling external trigger, reload mode
    task automatic t_ext();
        int n;
        logic [31:0] cfg;
        cfg = 32'h2 | RLD | EN | 32'h20;
        wr(8'h14, 32'h40);
        wr(MSK, 32'h2);
        wr(8'h10, cfg);
        rd(8'h10, cfg, "idle before trigger");
        u_pin_partner.pulse_trig(1);
        rd(8'h10, cfg | RUN, "running after trigger");
        wait_hi(1, n);
        rd(STA, 32'h2, "channel 1 status only");
        rd(8'h10, cfg | RUN, "still running");
        wr(8'h10, 32'h0);
        wr(STA, 32'h2);
        $display("test external trigger done");
    endtask

    // channel 1 counting event edges, rising then both, one-shot
    task automatic t_event();
        logic [31:0] cfg;
        cfg = 32'h3 | EN | 32'h10 | 32'h40;
        wr(8'h14, 32'h2);
        wr(8'h10, cfg);
        u_pin_partner.pulse_trig(1);
        rd(8'h10, cfg, "trigger ignored");
        wr(8'h10, cfg | SWT);
        rd(8'h18, 32'h2, "loaded on launch");
        u_pin_partner.pulse_event(1);
        u_pin_partner.pulse_event(1);
        rd(8'h18, 32'h0, "two edges counted");
        u_pin_partner.pulse_event(1);
        rd(STA, 32'h2, "event underflow");
        rd(8'h18, 32'hffff, "event one-shot halt");
        wr(8'h14, 32'h3);
        wr(8'h10, 32'h3 | EN | 32'hc0 | SWT);
        u_pin_partner.pulse_event(1);
        rd(8'h18, 32'h1, "both edges counted");
        $display("test event count done");
    endtask

    // reset held for twelve cycles, then the scenarios in turn
    initial begin
        failures = 0;
        check_count = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_reload();
        t_oneshot();
        t_ext();
        t_event();
        conclude();
    end
endmodule // reload_down_timer_test

`default_nettype wire
